//--- hw/rbp_pkg.sv
// Purpose: constants for the roi and binning text command parser
// Assumes: 40 MHz clock, ascii command bytes from a serial receiver
// Notes: commands end in carriage return; replies end in carriage return
//
// Overview of operation
// - help returns one text string naming every supported command.
// - sox n stores roi start x and replies OK; gox returns it.
// - soy n stores roi start y and replies OK; goy returns it.
// - siw n sets roi width and replies OK; giw returns it.
// - sih n sets roi height and replies OK; gih returns it.
// - srs n selects which region later region commands use; grs returns it.
// - src takes only 0 or 1, disabling or enabling selected region.
// - srx n sets selected region horizontal offset; grx returns it.
// - sry n sets selected region vertical offset; gry returns it.
// - srw n sets selected region width; grw returns it.
// - srh n sets selected region height; grh returns it.
// - binning engine select accepts only 0 (sensor); reads back 0.
// - vertical binning mode accepts only 0, meaning sum.
// - horizontal binning mode follows vertical mode; reads 0.
// - horizontal binning factor follows vertical factor; reads 1 or 2.
// - vertical binning takes 1 or 2; 2 only on mono variant.
package rbp_pkg;

   // ----------------------------------------
   // widths and sizes
   // ----------------------------------------
   localparam int VAL_W = 16;
   localparam int NUM_RGN = 8;
   localparam int RGN_W = 3;
   localparam int ENT_W = 65;
   localparam int MAX_CH = 5;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] SENSOR_W = 16'h0990;
   localparam logic [15:0] SENSOR_H = 16'h0800;
   localparam logic [ENT_W-1:0] ENT_RST = {1'b0, 16'h0000, 16'h0000, SENSOR_W, SENSOR_H};
   localparam logic [1:0] BIN_RST = 2'h1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0003;

   // ----------------------------------------
   // region entry field positions
   // ----------------------------------------
   localparam int E_EN = 64;
   localparam int E_OX = 48;
   localparam int E_OY = 32;
   localparam int E_W = 16;
   localparam int E_H = 0;

   // ----------------------------------------
   // apb map
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_ROI_XY = 8'h08;
   localparam logic [7:0] A_ROI_WH = 8'h0C;
   localparam logic [7:0] A_BIN = 8'h10;
   localparam int C_EN = 0;
   localparam int C_MONO = 1;

   // ----------------------------------------
   // characters and command bodies
   // ----------------------------------------
   localparam logic [7:0] CH_S = 8'h73;
   localparam logic [7:0] CH_G = 8'h67;
   localparam logic [7:0] CH_H = 8'h68;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_A = 8'h61;
   localparam logic [7:0] CH_Z = 8'h7A;
   localparam logic [23:0] B_OX = 24'h006F78;
   localparam logic [23:0] B_OY = 24'h006F79;
   localparam logic [23:0] B_IW = 24'h006977;
   localparam logic [23:0] B_IH = 24'h006968;
   localparam logic [23:0] B_RS = 24'h007273;
   localparam logic [23:0] B_RC = 24'h007263;
   localparam logic [23:0] B_RX = 24'h007278;
   localparam logic [23:0] B_RY = 24'h007279;
   localparam logic [23:0] B_RW = 24'h007277;
   localparam logic [23:0] B_RH = 24'h007268;
   localparam logic [23:0] B_BNS = 24'h626E73;
   localparam logic [23:0] B_BHM = 24'h62686D;
   localparam logic [23:0] B_BH = 24'h006268;
   localparam logic [23:0] B_BVM = 24'h62766D;
   localparam logic [23:0] B_BV = 24'h006276;
   localparam logic [23:0] B_ELP = 24'h656C70;

   // ----------------------------------------
   // reply texts
   // ----------------------------------------
   localparam int OK_LEN = 3;
   localparam logic [8*OK_LEN-1:0] OK_TXT = 24'h4F4B0D;
   localparam int ERR_LEN = 4;
   localparam logic [8*ERR_LEN-1:0] ERR_TXT = 32'h4552520D;
   localparam int HELP_LEN = 131;
   localparam logic [8*HELP_LEN-1:0] HELP_TXT =
      {"help sox gox soy goy siw giw sih gih srs grs src grc srx grx sry gry ",
       "srw grw srh grh sbns gbns sbhm gbhm sbh gbh sbvm gbvm sbv gbv", 8'h0D};
   localparam logic [1:0] TX_OK = 2'h0;
   localparam logic [1:0] TX_ERR = 2'h1;
   localparam logic [1:0] TX_HELP = 2'h2;
   localparam logic [2:0] LAST_POW = 3'h4;

   typedef enum logic [2:0] {ST_RECV, ST_EXEC, ST_TXT, ST_NUM, ST_END} rbp_state_t;

   function automatic logic [15:0] rbp_pow10(input logic [2:0] idx);
      case (idx)
         3'h0: rbp_pow10 = 16'h2710;
         3'h1: rbp_pow10 = 16'h03E8;
         3'h2: rbp_pow10 = 16'h0064;
         3'h3: rbp_pow10 = 16'h000A;
         default: rbp_pow10 = 16'h0001;
      endcase
   endfunction

endpackage

//--- hw/rbp_rgn_mem.sv
// Purpose: per-region geometry store with registered read data
// Assumes: one write port, one read port, same clock
// Notes: every entry resets to a disabled full-size region
`timescale 1ns/1ps
module rbp_rgn_mem
   import rbp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write port
   input wire logic wr_en,
   input wire logic [rbp_pkg::RGN_W-1:0] wr_addr,
   input wire logic [rbp_pkg::ENT_W-1:0] wr_data,
   // read port
   input wire logic [rbp_pkg::RGN_W-1:0] rd_addr,
   output logic [rbp_pkg::ENT_W-1:0] rd_data_ff
);
   logic [ENT_W-1:0] ent_ff [NUM_RGN];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_RGN; gi++) begin : g_ent
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ent_ff[gi] <= ENT_RST;
            end else if (wr_en && (wr_addr == RGN_W'(gi))) begin
               ent_ff[gi] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff <= ENT_RST;
      end else begin
         rd_data_ff <= ent_ff[rd_addr];
      end
   end
endmodule

//--- hw/rbp_top.sv
// Purpose: ascii set/get interpreter for roi, multi-region and binning
// Assumes: rx bytes come from same-clock serial logic as one-cycle strobes
// Notes: bytes arriving while a reply is in progress are dropped
`timescale 1ns/1ps
module rbp_top
   import rbp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // command bytes in
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   // reply bytes out
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // settings to the image path
   output logic [15:0] roi_off_x,
   output logic [15:0] roi_off_y,
   output logic [15:0] roi_width,
   output logic [15:0] roi_height,
   output logic [rbp_pkg::NUM_RGN-1:0] rgn_en_mask,
   output logic [1:0] bin_vert,
   output logic [1:0] bin_horz
);
   import rbp_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   rbp_state_t st_ff;
   logic [7:0] first_ff;
   logic [23:0] body_ff;
   logic [2:0] nch_ff;
   logic arg_ff, has_arg_ff, bad_ff;
   logic [15:0] acc_ff;
   logic [15:0] ox_ff, oy_ff, w_ff, h_ff;
   logic [RGN_W-1:0] sel_ff;
   logic [1:0] binv_ff;
   logic [NUM_RGN-1:0] en_mask_ff;
   logic [7:0] tx_data_ff;
   logic tx_valid_ff;
   logic [1:0] txt_sel_ff;
   logic [7:0] txt_idx_ff;
   logic [15:0] num_ff;
   logic [2:0] pow_ff;
   logic [3:0] dig_ff;
   logic started_ff;
   logic last_err_ff;
   logic [31:0] ctrl_ff, prdata_ff;
   logic pready_ff, pslverr_ff;
   logic [ENT_W-1:0] ent_rd;

   // ----------------------------------------
   // receive decode
   // ----------------------------------------
   wire parse_en = ctrl_ff[C_EN];
   wire mono = ctrl_ff[C_MONO];
   wire take = rx_valid && parse_en && (st_ff == ST_RECV);
   wire is_digit = (rx_data >= CH_0) && (rx_data <= CH_9);
   wire is_alpha = (rx_data >= CH_A) && (rx_data <= CH_Z);
   wire [20:0] acc_mul = ({5'h00, acc_ff} << 3) + ({5'h00, acc_ff} << 1)
                         + {17'h00000, rx_data[3:0]};
   wire acc_ovf = |acc_mul[20:16];
   wire is_set = (first_ff == CH_S);
   wire is_get = (first_ff == CH_G);
   wire is_help = (first_ff == CH_H) && (body_ff == B_ELP);
   wire [15:0] arg = acc_ff;
   wire tx_free = !tx_valid_ff || tx_ready;
   wire [15:0] pow_val = rbp_pow10(pow_ff);

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic known, rng_ok, wr_img, wr_rgn;
   logic [15:0] get_val;
   logic [ENT_W-1:0] ent_new;
   always_comb begin
      known = 1'b1;
      rng_ok = 1'b1;
      wr_img = 1'b0;
      wr_rgn = 1'b0;
      get_val = 16'h0000;
      ent_new = ent_rd;
      case (body_ff)
         B_OX: begin get_val = ox_ff; wr_img = 1'b1; end
         B_OY: begin get_val = oy_ff; wr_img = 1'b1; end
         B_IW: begin get_val = w_ff; wr_img = 1'b1; end
         B_IH: begin get_val = h_ff; wr_img = 1'b1; end
         B_RS: begin
            get_val = {13'h0000, sel_ff};
            rng_ok = (arg < 16'(NUM_RGN));
         end
         B_RC: begin
            get_val = {15'h0000, ent_rd[E_EN]};
            rng_ok = (arg <= 16'h0001);
            ent_new[E_EN] = arg[0];
            wr_rgn = 1'b1;
         end
         B_RX: begin
            get_val = ent_rd[E_OX +: 16];
            ent_new[E_OX +: 16] = arg;
            wr_rgn = 1'b1;
         end
         B_RY: begin
            get_val = ent_rd[E_OY +: 16];
            ent_new[E_OY +: 16] = arg;
            wr_rgn = 1'b1;
         end
         B_RW: begin
            get_val = ent_rd[E_W +: 16];
            ent_new[E_W +: 16] = arg;
            wr_rgn = 1'b1;
         end
         B_RH: begin
            get_val = ent_rd[E_H +: 16];
            ent_new[E_H +: 16] = arg;
            wr_rgn = 1'b1;
         end
         B_BNS: rng_ok = (arg == 16'h0000);
         B_BVM: rng_ok = (arg == 16'h0000);
         B_BHM: rng_ok = (arg == 16'h0000);
         B_BH: begin
            get_val = {14'h0000, binv_ff};
            rng_ok = (arg == {14'h0000, binv_ff});
         end
         B_BV: begin
            get_val = {14'h0000, binv_ff};
            rng_ok = (arg == 16'h0001) || (mono && (arg == 16'h0002));
         end
         default: known = 1'b0;
      endcase
   end

   wire set_err = is_set && (!has_arg_ff || !rng_ok);
   wire get_err = is_get && has_arg_ff;
   wire cmd_err = bad_ff || (!is_help && (!known || !(is_set || is_get)))
                  || set_err || get_err || (is_help && has_arg_ff);
   wire do_set = (st_ff == ST_EXEC) && !cmd_err && is_set;
   wire rgn_we = do_set && wr_rgn;

   rbp_rgn_mem u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(rgn_we),
      .wr_addr(sel_ff),
      .wr_data(ent_new),
      .rd_addr(sel_ff),
      .rd_data_ff(ent_rd)
   );

   // ----------------------------------------
   // reply character selection
   // ----------------------------------------
   wire [7:0] txt_len = (txt_sel_ff == TX_OK) ? 8'(OK_LEN) :
                        (txt_sel_ff == TX_ERR) ? 8'(ERR_LEN) : 8'(HELP_LEN);
   wire [7:0] ok_ch = OK_TXT[8*(OK_LEN-1-int'(txt_idx_ff[1:0])) +: 8];
   wire [7:0] err_ch = ERR_TXT[8*(ERR_LEN-1-int'(txt_idx_ff[1:0])) +: 8];
   wire [7:0] help_ch = HELP_TXT[8*(HELP_LEN-1-int'(txt_idx_ff)) +: 8];
   wire [7:0] txt_ch = (txt_sel_ff == TX_OK) ? ok_ch :
                       (txt_sel_ff == TX_ERR) ? err_ch : help_ch;
   wire num_sub = (st_ff == ST_NUM) && (num_ff >= pow_val);
   wire num_emit = (st_ff == ST_NUM) && !num_sub && tx_free
                   && ((dig_ff != 4'h0) || started_ff || (pow_ff == LAST_POW));

   // ----------------------------------------
   // parser and reply sequencer
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RECV;
         first_ff <= 8'h00;
         body_ff <= 24'h000000;
         nch_ff <= 3'h0;
         arg_ff <= 1'b0;
         has_arg_ff <= 1'b0;
         bad_ff <= 1'b0;
         acc_ff <= 16'h0000;
         txt_sel_ff <= TX_OK;
         txt_idx_ff <= 8'h00;
         num_ff <= 16'h0000;
         pow_ff <= 3'h0;
         dig_ff <= 4'h0;
         started_ff <= 1'b0;
         last_err_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_RECV: begin
               if (take) begin
                  if (rx_data == CH_CR) begin
                     st_ff <= ST_EXEC;
                  end else if (rx_data == CH_LF) begin
                     nch_ff <= nch_ff;
                  end else if (rx_data == CH_SP) begin
                     if (nch_ff == 3'h0 || arg_ff) begin
                        bad_ff <= bad_ff | has_arg_ff;
                     end
                     arg_ff <= (nch_ff != 3'h0);
                  end else if (arg_ff && is_digit) begin
                     acc_ff <= acc_mul[15:0];
                     has_arg_ff <= 1'b1;
                     bad_ff <= bad_ff | acc_ovf;
                  end else if (!arg_ff && is_alpha && nch_ff < 3'(MAX_CH)) begin
                     if (nch_ff == 3'h0) begin
                        first_ff <= rx_data;
                     end else begin
                        body_ff <= {body_ff[15:0], rx_data};
                     end
                     nch_ff <= nch_ff + 3'h1;
                     bad_ff <= bad_ff | (nch_ff == 3'(MAX_CH - 1));
                  end else begin
                     bad_ff <= 1'b1;
                  end
               end
            end
            ST_EXEC: begin
               last_err_ff <= cmd_err;
               txt_idx_ff <= 8'h00;
               num_ff <= get_val;
               pow_ff <= 3'h0;
               dig_ff <= 4'h0;
               started_ff <= 1'b0;
               if (cmd_err) begin
                  txt_sel_ff <= TX_ERR;
                  st_ff <= ST_TXT;
               end else if (is_help) begin
                  txt_sel_ff <= TX_HELP;
                  st_ff <= ST_TXT;
               end else if (is_set) begin
                  txt_sel_ff <= TX_OK;
                  st_ff <= ST_TXT;
               end else begin
                  st_ff <= ST_NUM;
               end
            end
            ST_TXT: begin
               if (tx_free) begin
                  txt_idx_ff <= txt_idx_ff + 8'h01;
                  if (txt_idx_ff == txt_len - 8'h01) begin
                     st_ff <= ST_RECV;
                  end
               end
            end
            ST_NUM: begin
               if (num_sub) begin
                  num_ff <= num_ff - pow_val;
                  dig_ff <= dig_ff + 4'h1;
               end else if (tx_free) begin
                  started_ff <= started_ff | num_emit;
                  dig_ff <= 4'h0;
                  pow_ff <= pow_ff + 3'h1;
                  if (pow_ff == LAST_POW) begin
                     st_ff <= ST_END;
                  end
               end
            end
            ST_END: begin
               if (tx_free) begin
                  st_ff <= ST_RECV;
               end
            end
            default: st_ff <= ST_RECV;
         endcase
         if (st_ff == ST_EXEC) begin
            first_ff <= 8'h00;
            body_ff <= 24'h000000;
            nch_ff <= 3'h0;
            arg_ff <= 1'b0;
            has_arg_ff <= 1'b0;
            bad_ff <= 1'b0;
            acc_ff <= 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // reply byte register
   // ----------------------------------------
   wire load_txt = (st_ff == ST_TXT) && tx_free;
   wire load_end = (st_ff == ST_END) && tx_free;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff <= 8'h00;
      end else if (load_txt || num_emit || load_end) begin
         tx_valid_ff <= 1'b1;
         tx_data_ff <= load_txt ? txt_ch : (load_end ? CH_CR : (CH_0 + {4'h0, dig_ff}));
      end else if (tx_ready) begin
         tx_valid_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // stored settings
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ox_ff <= 16'h0000;
         oy_ff <= 16'h0000;
         w_ff <= SENSOR_W;
         h_ff <= SENSOR_H;
         sel_ff <= '0;
         binv_ff <= BIN_RST;
         en_mask_ff <= '0;
      end else if (do_set) begin
         if (body_ff == B_OX) ox_ff <= arg;
         if (body_ff == B_OY) oy_ff <= arg;
         if (body_ff == B_IW) w_ff <= arg;
         if (body_ff == B_IH) h_ff <= arg;
         if (body_ff == B_RS) sel_ff <= arg[RGN_W-1:0];
         if (body_ff == B_RC) en_mask_ff[sel_ff] <= arg[0];
         if (body_ff == B_BV) binv_ff <= arg[1:0];
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   wire apb_setup = psel && !penable;
   wire apb_wr = psel && penable && pwrite && pready_ff;
   wire a_ok = (paddr == A_CTRL) || (paddr == A_STAT) || (paddr == A_ROI_XY)
               || (paddr == A_ROI_WH) || (paddr == A_BIN);
   wire [31:0] rd_mux =
      (paddr == A_CTRL) ? ctrl_ff :
      (paddr == A_STAT) ? {30'h00000000, last_err_ff, st_ff != ST_RECV} :
      (paddr == A_ROI_XY) ? {oy_ff, ox_ff} :
      (paddr == A_ROI_WH) ? {h_ff, w_ff} :
      (paddr == A_BIN) ? {16'h0000, en_mask_ff, 1'b0, sel_ff, binv_ff, binv_ff} :
      32'h00000000;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= CTRL_RST;
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= apb_setup;
         pslverr_ff <= apb_setup && !a_ok;
         prdata_ff <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
         if (apb_wr && paddr == A_CTRL) ctrl_ff <= {30'h00000000, pwdata[1:0]};
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign tx_data = tx_data_ff;
   assign tx_valid = tx_valid_ff;
   assign roi_off_x = ox_ff;
   assign roi_off_y = oy_ff;
   assign roi_width = w_ff;
   assign roi_height = h_ff;
   assign rgn_en_mask = en_mask_ff;
   assign bin_vert = binv_ff;
   assign bin_horz = binv_ff;
endmodule

//--- tb/rbp_host.sv
// Purpose: host sending text commands
// Assumes: reply ends in carriage return
// Notes: slow makes the sink stall at random
`timescale 1ns/1ps
module rbp_host (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command bytes
   output logic [7:0] rx_data,
   output logic rx_valid,
   // reply bytes
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   import rbp_pkg::*;
   logic slow = 1'b0;
   string rep;
   initial begin
      rx_data = 8'hFF;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   always @(posedge clk) begin
      if (tx_valid && tx_ready) rep = {rep, string'(tx_data)};
      tx_ready <= slow ? 1'($urandom) : 1'b1;
   end
   // one command out, whole reply back
   task automatic cmd(input string c, output string r);
      rep = "";
      @(posedge clk);
      for (int i = 0; i <= c.len(); i++) begin
         @(posedge clk);
         rx_data <= (i == c.len()) ? CH_CR : c[i];
         rx_valid <= 1'b1;
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~CH_CR;
      while (rep.len() == 0 || rep[rep.len()-1] != CH_CR) begin
         @(posedge clk);
      end
      r = rep;
   endtask
endmodule

//--- tb/rbp_top_properties.sv
// Purpose: port checks for rbp_top
// Assumes: one clock, async active-low reset
// Notes: bound to every rbp_top
`timescale 1ns/1ps
module rbp_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // reply
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   // settings
   input wire logic [15:0] roi_width,
   input wire logic [rbp_pkg::NUM_RGN-1:0] rgn_en_mask,
   input wire logic [1:0] bin_vert,
   input wire logic [1:0] bin_horz
);
   import rbp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence reply_s;
      ##[0:3] tx_valid;
   endsequence
   apb_answer_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte not held");
   bin_follow_a: assert property (bin_horz == bin_vert)
      else $error("horizontal factor differs");
   bin_range_a: assert property (bin_vert == 2'h1 || bin_vert == 2'h2)
      else $error("vertical factor out of range");
   width_reply_a: assert property ($changed(roi_width) |-> reply_s)
      else $error("width changed without reply");
   mask_reply_a: assert property ($changed(rgn_en_mask) |-> reply_s)
      else $error("mask changed without reply");
endmodule
bind rbp_top rbp_chk chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .roi_width(roi_width), .rgn_en_mask(rgn_en_mask),
   .bin_vert(bin_vert), .bin_horz(bin_horz));

//--- tb/rbp_top_test.sv
// Purpose: self-checking bench for rbp_top
// Assumes: host model carries the text traffic
// Notes: random values from a fixed seed
`timescale 1ns/1ps
module rbp_top_test;
   import rbp_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rx_valid, tx_valid, tx_ready;
   logic [7:0] paddr, rx_data, tx_data;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] roi_off_x, roi_off_y, roi_width, roi_height;
   logic [rbp_pkg::NUM_RGN-1:0] rgn_en_mask;
   logic [1:0] bin_vert, bin_horz;
   logic e;
   int miscompares, checks_done, cyc, v[8];
   string r, nm[8] = '{"ox", "oy", "iw", "ih", "rx", "ry", "rw", "rh"};
   string bz[3] = '{"bns", "bvm", "bhm"};
   rbp_top dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready,
      .roi_off_x, .roi_off_y, .roi_width, .roi_height, .rgn_en_mask, .bin_vert, .bin_horz);
   rbp_host host_u (.clk, .rst_n, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         results();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic string num(input int x);
      return $sformatf("%0d\r", x);
   endfunction
   task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", what, ex, got);
      end
   endtask
   task automatic run(input string c, input string ex);
      host_u.cmd(c, r);
      checks_done++;
      if (r != ex) begin
         miscompares++;
         $display("ERROR reply to %s expected %s seen %s", c, ex, r);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      void'($urandom(32'h31EF));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl", CTRL_RST, q);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      run("help", string'(HELP_TXT));
      run("sxyz 1", "ERR\r");
      apb(1'b0, A_STAT, 32'h0);
      chk("status", 32'h2, q);
      $display("test reset done");
      for (int k = 0; k < 16; k++) begin
         host_u.slow = k[0];
         v[k%8] = (k == 8) ? 65535 : (k == 9) ? 0 : int'($urandom % 65536);
         run($sformatf("s%s %0d", nm[k%8], v[k%8]), "OK\r");
         run({"g", nm[k%8]}, num(v[k%8]));
      end
      chk("roi_off_x", v[0], roi_off_x);
      chk("roi_off_y", v[1], roi_off_y);
      chk("roi_width", v[2], roi_width);
      chk("roi_height", v[3], roi_height);
      apb(1'b0, A_ROI_WH, 32'h0);
      chk("roi_wh", {v[3][15:0], v[2][15:0]}, q);
      run("sox 65536", "ERR\r");
      run("gox", num(v[0]));
      $display("test geometry done");
      run("srs 3", "OK\r");
      run("src 1", "OK\r");
      chk("mask", 32'h08, rgn_en_mask);
      run("src 2", "ERR\r");
      run("grc", num(1));
      run("srw 17", "OK\r");
      run("srs 7", "OK\r");
      run("grw", num(SENSOR_W));
      run("src 1", "OK\r");
      run("srs 3", "OK\r");
      run("grw", num(17));
      run("srs 8", "ERR\r");
      run("grs", num(3));
      run("src 0", "OK\r");
      chk("mask", 32'h80, rgn_en_mask);
      $display("test regions done");
      for (int j = 0; j < 3; j++) begin
         run({"s", bz[j], " 0"}, "OK\r");
         run({"s", bz[j], " 1"}, "ERR\r");
         run({"g", bz[j]}, num(0));
      end
      run("sbv 2", "OK\r");
      chk("bin_horz", 32'h2, bin_horz);
      chk("bin_vert", 32'h2, bin_vert);
      run("gbh", num(2));
      run("sbh 1", "ERR\r");
      run("sbv 3", "ERR\r");
      apb(1'b1, A_CTRL, 32'h1);
      run("sbv 1", "OK\r");
      run("sbv 2", "ERR\r");
      run("gbv", num(1));
      apb(1'b0, A_BIN, 32'h0);
      chk("bin reg", 32'h8035, q);
      $display("test binning done");
      results();
   end
endmodule
